// >>> inc/ast_defs.svh
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
// fixed target address, 7 bits
`define AST_TARGET_ADDR 7'h36
// clock period in ns (10 MHz)
`define AST_CLK_NS 100
// spike width to suppress in ns
`define AST_SPIKE_NS 50
// least filter length in cycles, rounded up, at least one
`define AST_SPIKE_CYC ((`AST_SPIKE_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
// implemented word address ranges (inclusive)
`define AST_CFG_LO 8'h00
`define AST_CFG_HI 8'h08
`define AST_MEAS_LO 8'h0B
`define AST_MEAS_HI 8'h1C
// high bytes of registers that hold the pointer on reads
`define AST_RAW_HI 8'h0C
`define AST_ANG_HI 8'h0E
`define AST_MAG_HI 8'h1B
`endif

// >>> inc/ast_pkg.sv
package ast_pkg;
  // byte transfer phases of the target
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} ast_state_t;
  // register side access, carried together
  typedef struct packed {
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ast_reg_req_t;
endpackage

// >>> test/ast_ctrl_model.sv
`timescale 1ns/1ps
// bus controller: makes every clock, start and stop; sda has a pull-up
module ast_ctrl_model
(
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  // idle bus, both lines high
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // one bit slot of 800 ns: low 500 ns so the target can turn sda round, high 300 ns
  task automatic slot(input logic b, input logic g, output logic r);
    #250 pull = ~b;
    #250 scl = 1'b1;
    if (g && b)
    begin
      #60 pull = 1'b1; // 40 ns spike, shorter than the filter
      #40 pull = 1'b0;
      #100 r = sda;
      #100 scl = 1'b0;
    end
    else
    begin
      #150 r = sda;
      #150 scl = 1'b0;
    end
  endtask
  // start or repeated start, ends with scl low
  task automatic start;
    #300 pull = 1'b0;
    #300 scl = 1'b1;
    #300 pull = 1'b1;
    #300 scl = 1'b0;
  endtask
  // stop, then the clock stands still high
  task automatic stop;
    #300 pull = 1'b1;
    #300 scl = 1'b1;
    #300 pull = 1'b0;
    #400;
  endtask
  // byte out, msb first; ack comes back low
  task automatic wbyte(input logic [7:0] b, input logic g, output logic ack);
    for (int i = 7; i >= 0; i--)
      slot(b[i], g, ack);
    slot(1'b1, 1'b0, ack);
  endtask
  // byte in; last byte is answered with a nack
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(1'b1, 1'b0, d[i]);
    slot(last, 1'b0, r);
  endtask
endmodule

// >>> test/ast_i2c_target_bench.sv
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_i2c_target_bench;
  logic                  clk = 1'b0;   // 10 MHz
  logic                  rst_n = 1'b0; // sync, active low
  logic [7:0]            salt = 8'h00; // random twist of register image
  logic                  scl;          // from controller
  logic                  pull;         // controller pulls sda
  logic                  sda_o;        // device data out
  logic                  sda_oe;       // device pulls sda
  logic [7:0]            reg_raddr;    // pointer on read side
  ast_pkg::ast_reg_req_t reg_req;      // write strobes
  logic [15:0]           stb_q[$];     // captured {addr, data}
  logic                  a;            // ack seen
  logic [7:0]            p;            // random pointer
  int                    error_cnt = 0;
  int                    checks = 0;
  wire                   sda = ~(pull | sda_oe); // open drain, pulled up
  wire  [7:0]            reg_rdata = img(reg_raddr);

  // register image, combinational as the port expects
  function automatic logic [7:0] img(input logic [7:0] x);
    return x ^ salt;
  endfunction
  // implemented word addresses
  function automatic logic ok(input logic [7:0] x);
    return x <= `AST_CFG_HI || (x >= `AST_MEAS_LO && x <= `AST_MEAS_HI);
  endfunction
  // high bytes that keep the pointer on reads
  function automatic logic hold(input logic [7:0] x);
    return x == `AST_RAW_HI || x == `AST_ANG_HI || x == `AST_MAG_HI;
  endfunction

  always #50 clk = ~clk;

  ast_ctrl_model m (.scl(scl), .pull(pull), .sda(sda));

  ast_i2c_target uut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
                      .sda_oe(sda_oe), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_raddr(reg_raddr));

  // collect write strobes
  always @(posedge clk)
    if (reg_req.wr_stb === 1'b1)
      stb_q.push_back({reg_req.addr, reg_req.wdata});

  // the device may only turn sda while the bus clock is low
  always @(sda_oe)
    if (rst_n)
      check("oe vs scl", scl, 1'b0);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // pointer byte then n random data bytes; g puts spikes on the address byte
  task automatic wr(input logic [7:0] q, input int n, input logic g);
    logic       k;
    logic [7:0] d;
    m.start();
    m.wbyte(8'h6C, g, k);
    check("addr ack", k, 1'b0);
    m.wbyte(q, 1'b0, k);
    check("ptr ack", k, !ok(q));
    repeat (n)
    begin
      d = 8'($urandom);
      m.wbyte(d, 1'b0, k);
      check("data ack", k, !ok(q));
      if (ok(q))
        check("strobe", stb_q.size() > 0 ? stb_q.pop_front() : 16'hXXXX, {q, d});
      q++;
    end
    m.stop();
    check("stray strobe", 16'(stb_q.size()), 16'h0000);
  endtask

  // set pointer, repeated start, read n bytes
  task automatic rd(input logic [7:0] q, input int n);
    logic       k;
    logic [7:0] d;
    m.start();
    m.wbyte(8'h6C, 1'b0, k);
    m.wbyte(q, 1'b0, k);
    m.start();
    m.wbyte(8'h6D, 1'b0, k);
    check("read addr ack", k, 1'b0);
    repeat (n)
    begin
      n--;
      m.rbyte(n == 0, d);
      check("read data", d, ok(q) ? img(q) : 8'h00);
      if (!hold(q))
        q++;
    end
    m.stop();
  endtask

  initial
  begin
    void'($urandom(56));
    salt = 8'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // keep every bus edge except the spike's leading edge a quarter period away from the clock edge
    #25;
    m.start();
    m.wbyte(8'h6A, 1'b0, a);
    check("foreign nack", a, 1'b1);
    m.stop();
    wr(8'h07, 5, 1'b0);
    wr(8'h06, 1, 1'b1);
    wr(8'hFE, 3, 1'b0);
    rd(8'h07, 5);
    rd(8'h0E, 3);
    rd(8'h1A, 3);
    rd(8'hFF, 2);
    repeat (6)
    begin
      p = 8'($urandom_range(0, 31));
      wr(p, 2, 1'b0);
      rd(p, 3);
    end
    check("sda_o", sda_o, 1'b0);
    stop_test();
  end

  // watchdog, about five times the expected run
  initial
  begin
    #4000000;
    error_cnt++;
    stop_test();
  end
endmodule

// >>> verilog/ast_i2c_target.sv
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_i2c_target
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  output ast_pkg::ast_reg_req_t      reg_req,
  input  wire logic [7:0]            reg_rdata,
  output logic [7:0]                 reg_raddr
);
  // valid word address decode, used for ack and for read data
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= `AST_CFG_HI) || (a >= `AST_MEAS_LO && a <= `AST_MEAS_HI);
  endfunction

  // three stage synchronisers, then stable filter
  logic [2:0] sy_scl_ff;
  logic [2:0] sy_sda_ff;
  logic       scl_ff;                 // filtered clock level
  logic       sda_ff;                 // filtered data level
  logic       scl_d_ff;               // filtered clock, one cycle late
  logic       sda_d_ff;               // filtered data, one cycle late
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sy_scl_ff <= 3'h7;
      sy_sda_ff <= 3'h7;
    end
    else
    begin
      sy_scl_ff <= {sy_scl_ff[1:0], scl_i};
      sy_sda_ff <= {sy_sda_ff[1:0], sda_i};
    end
  end
  // a change is taken only when stages two and three agree, i.e. it lasted
  // at least one full 100 ns cycle, which covers the 50 ns spike limit
  wire scl_agree = (sy_scl_ff[1] == sy_scl_ff[2]);
  wire sda_agree = (sy_sda_ff[1] == sy_sda_ff[2]);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      scl_d_ff <= 1'b1;               // idle high, so no false edge after reset
      sda_d_ff <= 1'b1;
    end
    else
    begin
      if (scl_agree)
        scl_ff <= sy_scl_ff[2];
      if (sda_agree)
        sda_ff <= sy_sda_ff[2];
      // previous filtered levels for edge detection
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end
  // conditions: sda moves while scl stays high
  wire scl_rise = scl_ff & ~scl_d_ff;
  wire scl_fall = ~scl_ff & scl_d_ff;
  wire start_c  = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
  wire stop_c   = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;

  // byte engine state
  ast_pkg::ast_state_t state_ff;
  logic [7:0] shift_ff;               // incoming or outgoing byte
  logic [3:0] bit_ff;                 // bits seen in this byte
  logic [7:0] ptr_ff;                 // word address pointer
  logic       first_ff;               // next write byte loads pointer
  logic       rd_ff;                  // direction of current transfer
  logic       nack_ff;                // master declined read data
  logic       drive_ff;               // pull sda low
  logic       ack_ff;                 // data byte taken, acked or not; pointer steps
  logic       wstb_ff;                // write strobe to registers

  wire byte_done = scl_fall & (bit_ff == 4'h8);
  wire addr_hit  = (shift_ff[7:1] == `AST_TARGET_ADDR);
  // pointer holds on the measurement high bytes during reads
  wire ptr_hold  = (ptr_ff == `AST_RAW_HI) || (ptr_ff == `AST_ANG_HI) || (ptr_ff == `AST_MAG_HI);
  wire [7:0] rd_byte = addr_ok(ptr_ff) ? reg_rdata : 8'h00;

  assign reg_raddr      = ptr_ff;
  assign reg_req.wr_stb = wstb_ff;
  assign reg_req.addr   = ptr_ff;
  assign reg_req.wdata  = shift_ff;
  // open drain: only low is ever driven, clock never driven
  assign sda_o  = 1'b0;
  assign sda_oe = drive_ff;

  // main sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= ast_pkg::ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff   <= 4'h0;
      ptr_ff   <= 8'h00;
      first_ff <= 1'b0;
      rd_ff    <= 1'b0;
      nack_ff  <= 1'b0;
      drive_ff <= 1'b0;
      ack_ff   <= 1'b0;
      wstb_ff  <= 1'b0;
    end
    else
    begin
      wstb_ff <= 1'b0;
      if (stop_c)
      begin
        // bus released, go quiet
        state_ff <= ast_pkg::ST_IDLE;
        drive_ff <= 1'b0;
      end
      else if (start_c)
      begin
        // start or repeated start: fresh address byte
        state_ff <= ast_pkg::ST_ADDR;
        bit_ff   <= 4'h0;
        drive_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ast_pkg::ST_IDLE:
          begin
            drive_ff <= 1'b0;
          end
          ast_pkg::ST_ADDR, ast_pkg::ST_WR:
          begin
            if (scl_rise)
            begin
              shift_ff <= {shift_ff[6:0], sda_ff};
              bit_ff   <= bit_ff + 4'h1;
            end
            else if (byte_done)
            begin
              bit_ff <= 4'h0;
              if (state_ff == ast_pkg::ST_ADDR)
              begin
                // foreign address: ignore until next start
                if (addr_hit)
                begin
                  rd_ff    <= shift_ff[0];
                  first_ff <= ~shift_ff[0];
                  drive_ff <= 1'b1;
                  state_ff <= ast_pkg::ST_ADDR_ACK;
                end
                else
                  state_ff <= ast_pkg::ST_IDLE;
              end
              else
              begin
                if (first_ff)
                begin
                  ptr_ff   <= shift_ff;
                  first_ff <= 1'b0;
                  drive_ff <= addr_ok(shift_ff);
                end
                else
                begin
                  wstb_ff  <= addr_ok(ptr_ff);
                  drive_ff <= addr_ok(ptr_ff);
                  ack_ff   <= 1'b1;
                end
                state_ff <= ast_pkg::ST_WR_ACK;
              end
            end
          end
          ast_pkg::ST_ADDR_ACK:
          begin
            // leave ack on the falling edge
            if (scl_fall)
            begin
              if (rd_ff)
              begin
                shift_ff <= {rd_byte[6:0], 1'b0};
                drive_ff <= ~rd_byte[7];
                bit_ff   <= 4'h0;
                state_ff <= ast_pkg::ST_RD;
              end
              else
              begin
                drive_ff <= 1'b0;
                state_ff <= ast_pkg::ST_WR;
              end
            end
          end
          ast_pkg::ST_WR_ACK:
          begin
            if (scl_fall)
            begin
              drive_ff <= 1'b0;
              // pointer advances after each data byte
              if (ack_ff)
                ptr_ff <= ptr_ff + 8'h01;
              ack_ff   <= 1'b0;
              state_ff <= ast_pkg::ST_WR;
            end
          end
          ast_pkg::ST_RD:
          begin
            if (scl_rise)
              bit_ff <= bit_ff + 4'h1;
            else if (scl_fall)
            begin
              if (bit_ff == 4'h8)
              begin
                drive_ff <= 1'b0;  // release for master ack
                state_ff <= ast_pkg::ST_RD_ACK;
                if (!ptr_hold)
                  ptr_ff <= ptr_ff + 8'h01;
              end
              else
              begin
                drive_ff <= ~shift_ff[7];
                shift_ff <= {shift_ff[6:0], 1'b0};
              end
            end
          end
          ast_pkg::ST_RD_ACK:
          begin
            if (scl_rise)
              nack_ff <= sda_ff;
            else if (scl_fall)
            begin
              if (nack_ff)
              begin
                drive_ff <= 1'b0;  // leave sda high for stop
                state_ff <= ast_pkg::ST_IDLE;
              end
              else
              begin
                shift_ff <= {rd_byte[6:0], 1'b0};
                drive_ff <= ~rd_byte[7];
                bit_ff   <= 4'h0;
                state_ff <= ast_pkg::ST_RD;
              end
            end
          end
          default:
          begin
            state_ff <= ast_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // no speed setting exists; edge detection on a 10 MHz clock serves all grades

  // sda drive may only change while scl is low (filtered view)
  chk_sda_scl_low: assert property (@(posedge clk) disable iff (!rst_n)
    (sda_oe != $past(sda_oe)) |-> !scl_d_ff) else $error("sda drive changed while scl high");
  chk_addr_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_ADDR && byte_done && !start_c && !stop_c && !addr_hit) |=> !sda_oe)
    else $error("acked foreign address");
  chk_ptr_load: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_WR && byte_done && first_ff && !start_c && !stop_c) |=> ptr_ff == $past(shift_ff))
    else $error("pointer not loaded");
  chk_bad_nack: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_WR && byte_done && !first_ff && !addr_ok(ptr_ff) && !start_c && !stop_c)
    |=> !sda_oe && !wstb_ff) else $error("acked bad address");
  chk_rd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_RD_ACK && scl_fall && !nack_ff && !addr_ok(ptr_ff) && !start_c && !stop_c)
    |=> sda_oe) else $error("bad address read not zero");
  chk_ptr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_RD && scl_fall && bit_ff == 4'h8 && ptr_hold && !start_c && !stop_c)
    |=> $stable(ptr_ff)) else $error("pointer moved on held register");
  chk_rd_incr: assert property (@(posedge clk) disable iff (!rst_n)
    (state_ff == ast_pkg::ST_RD && scl_fall && bit_ff == 4'h8 && !ptr_hold && !start_c && !stop_c)
    |=> ptr_ff == $past(ptr_ff) + 8'h01) else $error("pointer not advanced");
  chk_filter_spike: assert property (@(posedge clk) disable iff (!rst_n)
    (sy_scl_ff[2] != sy_scl_ff[1]) |=> $stable(scl_ff)) else $error("clock spike passed filter");
  chk_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
    stop_c |=> state_ff == ast_pkg::ST_IDLE && !sda_oe) else $error("stop not obeyed");
endmodule
